// ==== src/fsp_pkg.sv ====
// Shared constants for the page-operation flash sequencer and its host end
package fsp_pkg;
  // Opcodes
  localparam logic [7:0] OP_XFR_B1 = 8'h53;
  localparam logic [7:0] OP_XFR_B2 = 8'h55;
  localparam logic [7:0] OP_CMP_B1 = 8'h60;
  localparam logic [7:0] OP_CMP_B2 = 8'h61;
  localparam logic [7:0] OP_RW_B1  = 8'h58;
  localparam logic [7:0] OP_RW_B2  = 8'h59;
  localparam logic [7:0] OP_STATUS = 8'hD7;
  // Timing, core clock period and operation times in ns
  localparam int CLK_PERIOD_NS   = 50;
  localparam int XFR_TIME_NS     = 200_000;
  localparam int CMP_TIME_NS     = 200_000;
  localparam int REWRITE_TIME_NS = 25_000_000;
  localparam int XFR_CYC     = XFR_TIME_NS / CLK_PERIOD_NS;
  localparam int CMP_CYC     = CMP_TIME_NS / CLK_PERIOD_NS;
  localparam int REWRITE_CYC = REWRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int BUSY_W      = 20;
  // Status byte one bit positions
  localparam int ST_RDY_BIT  = 7;
  localparam int ST_COMP_BIT = 6;
  localparam int ST_SIZE_LSB = 2;
  localparam int ST_PROT_BIT = 1;
  localparam int ST_PGSZ_BIT = 0;
  // Status byte two bit positions
  localparam int B2_FAULT_BIT = 5;
  localparam int B2_LOCK_BIT  = 3;
  localparam int B2_PS2_BIT   = 2;
  localparam int B2_PS1_BIT   = 1;
  localparam int B2_ES_BIT    = 0;
  // Size class code, value is arbitrary
  localparam logic [3:0] SIZE_CODE_DEF = 4'hA;
  // Address byte layout
  localparam int PAGE_W       = 11;
  localparam int STD_PAGE_LSB = 9;
  localparam int BIN_PAGE_LSB = 8;
  // Link bit counts
  localparam logic [5:0] OPC_BITS  = 6'h08;
  localparam logic [5:0] ADDR_END  = 6'h20;
  localparam logic [5:0] DATA_END  = 6'h28;
  localparam logic [5:0] RD_CLOCKS = 6'h18;
  // Host link clock half period in core cycles, minus one
  localparam logic [1:0] SCK_HALF_M1 = 2'h3;
  // Host APB map and command fields
  localparam logic [7:0] REG_CMD  = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_PAGE_LSB = 8;
  localparam int CMD_BIN_BIT  = 19;
  localparam int CMD_DATA_BIT = 20;
  localparam int CMD_DATA_LSB = 24;
  localparam int STAT_BUSY_BIT = 16;
endpackage

// ==== src/fsp_if.sv ====
// Serial link between the flash sequencer and its host controller
`timescale 1ns/10ps
interface fsp_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  modport dev (input cs_n, input sck, input si, output so, output so_oe);
  modport host (output cs_n, output sck, output si, input so);
endinterface

// ==== src/fsp_dev.sv ====
// Flash device end: command decode, page operations and status read
// Notes on behaviour
// - 53h/55h transfer page into buffer one/two
// - Standard pages: 4 dummy, 11 page, 9 dummy
// - Binary pages: 5 dummy, 11 page, 8 dummy
// - Host keeps select low while shifting
// - Transfer starts at select rise, busy meanwhile
// - 60h/61h compare page with buffer one/two
// - Compare busy, then result into bit 6
// - Compare flag 0 on match, 1 otherwise
// - 58h/59h rewrite page through buffer one/two
// - Rewrite copies and reprograms, busy meanwhile
// - Data after address means read-modify-write
// - Host refreshes pages within 50,000 operations; fsp_host keeps no count and rewrites only on command
// - D7h starts status output on SO
// - Status bytes repeat, freshly sampled each time
// - Status read accepted even while busy
// - Ready flag bit 7, both bytes, resampled
// - Select rise ends read, releases SO
// - Bits 5:2 hold fixed size code
// - Bit 1 shows sector protection
// - Bit 0 shows page length choice
// - Byte two holds fault, lockdown, suspend flags
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/10ps
module fsp_dev
  import fsp_pkg::*;
#(
  parameter int         XFR_CYCLES     = XFR_CYC,
  parameter int         CMP_CYCLES     = CMP_CYC,
  parameter int         REWRITE_CYCLES = REWRITE_CYC,
  parameter logic [3:0] SIZE_CODE      = SIZE_CODE_DEF
) (
  input  wire logic                CORE_CLK_I,
  input  wire logic                SYS_RST_I,
  fsp_if.dev                       LINK,
  input  wire logic                PAGE_BIN_I,
  input  wire logic                PROTECT_I,
  input  wire logic                MISMATCH_I,
  input  wire logic                PROG_FAULT_I,
  input  wire logic                LOCKDOWN_OK_I,
  input  wire logic                BUF1_SUSP_I,
  input  wire logic                BUF2_SUSP_I,
  input  wire logic                ERASE_SUSP_I,
  output logic                     OP_START_O,
  output logic [7:0]               OP_CODE_O,
  output logic [PAGE_W-1:0]        OP_PAGE_O,
  output logic                     OP_BUF2_O,
  output logic                     OP_RMW_O,
  output logic                     BUSY_O,
  output logic                     COMPARE_FLAG_O
);

  typedef enum logic [1:0] {DS_IDLE, DS_RECV, DS_STAT} fsp_dst_type;

  typedef struct packed {
    fsp_dst_type        st;
    logic               cs1;
    logic               cs2;
    logic               sk1;
    logic               sk2;
    logic               sk_q;
    logic               si1;
    logic               si2;
    logic [31:0]        sr;
    logic [5:0]         cnt;
    logic [7:0]         op;
    logic [23:0]        addr;
    logic               rmw;
    logic               so;
    logic               oe;
    logic [7:0]         sh;
    logic [3:0]         idx;
    logic [BUSY_W-1:0]  bcnt;
    logic               cmp_pend;
    logic               comp;
    logic               start;
    logic [7:0]         op_o;
    logic [PAGE_W-1:0]  page_o;
    logic               buf2_o;
    logic               rmw_o;
  } fsp_dev_type;

  localparam fsp_dev_type DEV_RST = '{st: DS_IDLE, cs1: 1'b1, cs2: 1'b1, default: '0};

  fsp_dev_type r;
  fsp_dev_type n;

  // Page operations that start on the select rise
  function automatic logic is_page_op(input logic [7:0] op);
    is_page_op = (op == OP_XFR_B1) || (op == OP_XFR_B2) ||
                 (op == OP_CMP_B1) || (op == OP_CMP_B2) ||
                 (op == OP_RW_B1)  || (op == OP_RW_B2);
  endfunction

  function automatic logic is_rw(input logic [7:0] op);
    is_rw = (op == OP_RW_B1) || (op == OP_RW_B2);
  endfunction

  function automatic logic is_cmp(input logic [7:0] op);
    is_cmp = (op == OP_CMP_B1) || (op == OP_CMP_B2);
  endfunction

  logic              rise;
  logic              fall;
  logic              busy;
  logic [7:0]        byte_one;
  logic [7:0]        byte_two;
  logic [7:0]        cur_byte;
  logic [7:0]        new_op;
  logic [BUSY_W-1:0] dur;

  // Edge detection on the synchronised link clock
  assign rise = r.sk2 & ~r.sk_q;
  assign fall = ~r.sk2 & r.sk_q;
  assign busy = (r.bcnt != '0);

  // Status contents, rebuilt from live state whenever a byte begins
  always_comb begin
    byte_one              = '0;
    byte_one[ST_RDY_BIT]  = ~busy;
    byte_one[ST_COMP_BIT] = r.comp;
    byte_one[ST_SIZE_LSB +: 4] = SIZE_CODE;
    byte_one[ST_PROT_BIT] = PROTECT_I;
    byte_one[ST_PGSZ_BIT] = PAGE_BIN_I;
    byte_two               = '0;
    byte_two[ST_RDY_BIT]   = ~busy;
    byte_two[B2_FAULT_BIT] = PROG_FAULT_I;
    byte_two[B2_LOCK_BIT]  = LOCKDOWN_OK_I;
    byte_two[B2_PS2_BIT]   = BUF2_SUSP_I;
    byte_two[B2_PS1_BIT]   = BUF1_SUSP_I;
    byte_two[B2_ES_BIT]    = ERASE_SUSP_I;
    cur_byte = r.idx[3] ? byte_two : byte_one;
  end

  // Busy duration by operation kind
  always_comb begin
    if (is_rw(r.op)) begin
      dur = BUSY_W'(REWRITE_CYCLES);
    end else if (is_cmp(r.op)) begin
      dur = BUSY_W'(CMP_CYCLES);
    end else begin
      dur = BUSY_W'(XFR_CYCLES);
    end
  end

  assign new_op = {r.sr[6:0], r.si2};

  // Next state of the whole device
  always_comb begin
    n       = r;
    n.start = 1'b0;
    // Two-flop synchronisers on every link input
    n.cs1  = LINK.cs_n;
    n.cs2  = r.cs1;
    n.sk1  = LINK.sck;
    n.sk2  = r.sk1;
    n.sk_q = r.sk2;
    n.si1  = LINK.si;
    n.si2  = r.si1;
    // Busy countdown; the compare outcome lands as busy ends
    if (busy) begin
      n.bcnt = r.bcnt - 1'b1;
      if (r.bcnt == BUSY_W'(1) && r.cmp_pend) begin
        n.comp     = MISMATCH_I;
        n.cmp_pend = 1'b0;
      end
    end
    case (r.st)
      DS_IDLE: begin
        n.oe = 1'b0;
        if (!r.cs2) begin
          n.st  = DS_RECV;
          n.cnt = '0;
          n.rmw = 1'b0;
        end
      end
      DS_RECV: begin
        if (r.cs2) begin
          n.st = DS_IDLE;
          // Commands arriving while busy are dropped, only status is served
          if (is_page_op(r.op) && r.cnt >= ADDR_END && !busy) begin
            n.start  = 1'b1;
            n.op_o   = r.op;
            n.buf2_o = (r.op == OP_XFR_B2) || (r.op == OP_CMP_B2) ||
                       (r.op == OP_RW_B2);
            n.page_o = PAGE_BIN_I ? r.addr[BIN_PAGE_LSB +: PAGE_W]
                                  : r.addr[STD_PAGE_LSB +: PAGE_W];
            n.rmw_o    = r.rmw & is_rw(r.op);
            n.bcnt     = dur;
            n.cmp_pend = is_cmp(r.op);
          end
        end else if (rise) begin
          n.sr = {r.sr[30:0], r.si2};
          if (r.cnt != DATA_END) begin
            n.cnt = r.cnt + 1'b1;
          end
          if (r.cnt == OPC_BITS - 1'b1) begin
            n.op = new_op;
            if (new_op == OP_STATUS) begin
              n.st  = DS_STAT;
              n.idx = '0;
            end
          end
          if (r.cnt == ADDR_END - 1'b1) begin
            n.addr = {r.sr[22:0], r.si2};
          end
          if (r.cnt == DATA_END - 1'b1) begin
            n.rmw = 1'b1;
          end
        end
      end
      DS_STAT: begin
        if (r.cs2) begin
          n.st = DS_IDLE;
          n.oe = 1'b0;
        end else if (fall) begin
          n.oe = 1'b1;
          // Launch on falling edges so the host samples a settled bit
          if (r.idx[2:0] == 3'h0) begin
            n.so = cur_byte[7];
            n.sh = {cur_byte[6:0], 1'b0};
          end else begin
            n.so = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
          end
          n.idx = r.idx + 1'b1;
        end
      end
      default: begin
        n.st = DS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      r <= DEV_RST;
    end else begin
      r <= n;
    end
  end

  assign LINK.so        = r.so;
  assign LINK.so_oe     = r.oe;
  assign OP_START_O     = r.start;
  assign OP_CODE_O      = r.op_o;
  assign OP_PAGE_O      = r.page_o;
  assign OP_BUF2_O      = r.buf2_o;
  assign OP_RMW_O       = r.rmw_o;
  assign BUSY_O         = busy;
  assign COMPARE_FLAG_O = r.comp;

endmodule

// ==== src/fsp_host.sv ====
// Host end: APB command registers driving the serial flash link
`timescale 1ns/10ps
module fsp_host
  import fsp_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        SYS_RST_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  fsp_if.host              LINK
);

  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_END, HS_GAP} fsp_hst_type;

  typedef struct packed {
    fsp_hst_type  st;
    logic         so1;
    logic         so2;
    logic         cs_n;
    logic         sck;
    logic         si;
    logic [39:0]  tx;
    logic [5:0]   nclk;
    logic [5:0]   cnt;
    logic [1:0]   div;
    logic         rd;
    logic [15:0]  rx;
    logic [15:0]  stat;
    logic [31:0]  prdata;
  } fsp_host_type;

  localparam fsp_host_type HOST_RST = '{st: HS_IDLE, cs_n: 1'b1, default: '0};

  fsp_host_type r;
  fsp_host_type n;

  logic        mapped;
  logic        wr_cmd;
  logic [7:0]  op;
  logic [10:0] page;
  logic [23:0] addr;
  logic        tick;

  assign mapped = (PADDR_I == REG_CMD) || (PADDR_I == REG_STAT);
  assign wr_cmd = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == REG_CMD);
  assign op     = PWDATA_I[7:0];
  assign page   = PWDATA_I[CMD_PAGE_LSB +: PAGE_W];
  assign tick   = (r.div == SCK_HALF_M1);

  // Page address placed per the configured page length
  always_comb begin
    addr = '0;
    if (PWDATA_I[CMD_BIN_BIT]) begin
      addr[BIN_PAGE_LSB +: PAGE_W] = page;
    end else begin
      addr[STD_PAGE_LSB +: PAGE_W] = page;
    end
  end

  // Next state: register access and link sequencing
  always_comb begin
    n     = r;
    n.so1 = LINK.so;
    n.so2 = r.so1;
    // Read data is prepared in the setup phase, so no wait states
    if (PSEL_I && !PENABLE_I) begin
      n.prdata = '0;
      if (PADDR_I == REG_STAT) begin
        n.prdata[15:0]         = r.stat;
        n.prdata[STAT_BUSY_BIT] = (r.st != HS_IDLE);
      end
    end
    case (r.st)
      HS_IDLE: begin
        // A command written while the link is busy is ignored
        if (wr_cmd) begin
          n.st   = HS_RUN;
          n.cs_n = 1'b0;
          n.sck  = 1'b0;
          n.div  = '0;
          n.cnt  = '0;
          n.rx   = '0;
          n.rd   = (op == OP_STATUS);
          if (op == OP_STATUS) begin
            n.tx   = {op, 32'h0000_0000};
            n.nclk = RD_CLOCKS;
          end else begin
            n.tx   = {op, addr, PWDATA_I[CMD_DATA_LSB +: 8]};
            n.nclk = PWDATA_I[CMD_DATA_BIT] ? DATA_END : ADDR_END;
          end
          n.si = op[7];
        end
      end
      HS_RUN: begin
        n.div = r.div + 1'b1;
        if (tick) begin
          n.div = '0;
          if (!r.sck) begin
            n.sck = 1'b1;
          end else begin
            n.sck = 1'b0;
            // Bit launched at the previous fall is settled by now
            if (r.rd && r.cnt >= OPC_BITS) begin
              n.rx = {r.rx[14:0], r.so2};
            end
            if (r.cnt == r.nclk - 1'b1) begin
              n.st = HS_END;
            end else begin
              n.cnt = r.cnt + 1'b1;
              n.tx  = {r.tx[38:0], 1'b0};
              n.si  = r.tx[38];
            end
          end
        end
      end
      HS_END: begin
        n.div = r.div + 1'b1;
        if (tick) begin
          n.div  = '0;
          n.cs_n = 1'b1;
          n.st   = HS_GAP;
          if (r.rd) begin
            n.stat = r.rx;
          end
        end
      end
      HS_GAP: begin
        n.div = r.div + 1'b1;
        if (tick) begin
          n.div = '0;
          n.st  = HS_IDLE;
        end
      end
      default: begin
        n.st = HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  assign PRDATA_O  = r.prdata;
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~mapped;
  assign LINK.cs_n = r.cs_n;
  assign LINK.sck  = r.sck;
  assign LINK.si   = r.si;

endmodule

// ==== sim/fsp_monitor.sv ====
// Link protocol checker watching the serial wires between host and device
`timescale 1ns/10ps
module fsp_monitor
  import fsp_pkg::*;
(
  input  wire logic CORE_CLK_I,
  input  wire logic SYS_RST_I,
  input  wire logic CS_N_I,
  input  wire logic SCK_I,
  input  wire logic SI_I,
  input  wire logic SO_I,
  input  wire logic SO_OE_I
);
  logic       sck_q;
  logic [5:0] rise_cnt;
  logic [7:0] opc;
  logic       stat_opc_done;

  // Count link clock rises in a frame; the opcode freezes after eight bits
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sck_q    <= 1'b0;
      rise_cnt <= 6'h00;
      opc      <= 8'h00;
    end else begin
      sck_q <= SCK_I;
      if (CS_N_I) begin
        rise_cnt <= 6'h00;
        opc      <= 8'h00;
      end else if (SCK_I && !sck_q && rise_cnt != 6'h3F) begin
        rise_cnt <= rise_cnt + 6'h01;
        if (rise_cnt < OPC_BITS) opc <= {opc[6:0], SI_I};
      end
    end
  end

  // Ninth rise of a status frame; data out must be on within four cycles of it
  assign stat_opc_done = SCK_I && !sck_q && !CS_N_I && rise_cnt == 6'h08 && opc == OP_STATUS;

  default clocking mon_cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // Sync delay of the device lets the release lag select by a few cycles
  chk_so_release: assert property ($rose(CS_N_I) |-> ##[1:6] !SO_OE_I)
    else $error("data out still driven after select rose");
  chk_oe_idle: assert property (CS_N_I [*8] |-> !SO_OE_I)
    else $error("data out driven while deselected");
  chk_sck_frame: assert property (SCK_I |-> !CS_N_I)
    else $error("link clock high outside a frame");
  chk_frame_start: assert property ($fell(CS_N_I) |-> !SCK_I [*4])
    else $error("link clock not idle low at frame start");
  chk_si_stable: assert property (SCK_I && !CS_N_I |-> $stable(SI_I))
    else $error("host data changed while link clock high");
  chk_oe_after_opc: assert property (stat_opc_done |-> ##[0:4] SO_OE_I)
    else $error("status output missing after status opcode");
  chk_no_oe_other: assert property (rise_cnt >= 6'h08 && opc != OP_STATUS |-> !SO_OE_I)
    else $error("data out driven for a non-status command");
  chk_oe_early: assert property (SO_OE_I && !CS_N_I |-> rise_cnt >= 6'h08)
    else $error("data out driven before opcode complete");

  cov_status: cover property (rise_cnt == 6'h08 && opc == OP_STATUS);
  cov_page:   cover property ($rose(CS_N_I) && $past(rise_cnt) == 6'h20);
  cov_rmw:    cover property ($rose(CS_N_I) && $past(rise_cnt) == 6'h28);
  cov_so_one: cover property (SO_OE_I && SO_I);
endmodule

// ==== sim/tb.sv ====
// Bench joining host and device ends over the serial link
`timescale 1ns/10ps
module tb;
  import fsp_pkg::*;
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
  localparam int RW_T = 2000;
  logic        core_clk = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, last_err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic        pready, pslverr;
  logic        pg_bin = 1'b0, prot = 1'b0, mism = 1'b0, fault = 1'b0;
  logic        lock = 1'b0, s1 = 1'b0, s2 = 1'b0, es = 1'b0, cmp_exp = 1'b0;
  logic        op_start, op_buf2, op_rmw, busy, cmp_flag, bad;
  logic [7:0]  op_code;
  logic [10:0] op_page;
  logic [15:0] st;
  int          n_fail = 0, checks_done = 0, bcnt = 0, cyc = 0;
  logic [7:0]  ops [6] = '{OP_XFR_B1, OP_XFR_B2, OP_CMP_B1, OP_CMP_B2, OP_RW_B1, OP_RW_B2};

  fsp_if link();
  fsp_dev #(.XFR_CYCLES(20), .CMP_CYCLES(20), .REWRITE_CYCLES(RW_T)) fsp_dev_i (
    .CORE_CLK_I(core_clk), .SYS_RST_I(rst), .LINK(link), .PAGE_BIN_I(pg_bin),
    .PROTECT_I(prot), .MISMATCH_I(mism), .PROG_FAULT_I(fault), .LOCKDOWN_OK_I(lock),
    .BUF1_SUSP_I(s1), .BUF2_SUSP_I(s2), .ERASE_SUSP_I(es), .OP_START_O(op_start),
    .OP_CODE_O(op_code), .OP_PAGE_O(op_page), .OP_BUF2_O(op_buf2), .OP_RMW_O(op_rmw),
    .BUSY_O(busy), .COMPARE_FLAG_O(cmp_flag));
  fsp_host fsp_host_i (
    .CORE_CLK_I(core_clk), .SYS_RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(link));
  fsp_monitor fsp_monitor_i (
    .CORE_CLK_I(core_clk), .SYS_RST_I(rst), .CS_N_I(link.cs_n), .SCK_I(link.sck),
    .SI_I(link.si), .SO_I(link.so), .SO_OE_I(link.so_oe));

  always #25 core_clk = ~core_clk;
  // Busy cycles seen at settled points; cleared before each operation
  always @(negedge core_clk) if (busy === 1'b1) bcnt++;
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 60000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    pen <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask

  // Poll until the link is free; the last read holds both status bytes
  task automatic idle();
    do apb(1'b0, REG_STAT, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
  endtask

  task automatic status();
    apb(1'b1, REG_CMD, {24'h0, OP_STATUS});
    idle();
    st = rd[15:0];
  endtask

  function automatic logic [15:0] exp_st(input logic bsy);
    return {~bsy, cmp_exp, SIZE_CODE_DEF, prot, pg_bin, ~bsy, 1'b0, fault, 1'b0, lock, s2, s1, es};
  endfunction

  task automatic page_op(input logic [7:0] op, input logic rmw);
    logic [10:0] pg;
    logic        bin, rw;
    pg = 11'($urandom);
    bin = 1'($urandom);
    rw = (op == OP_RW_B1) || (op == OP_RW_B2);
    {prot, mism, fault, lock, s1, s2, es} <= 7'($urandom);
    pg_bin <= bin;
    bcnt = 0;
    apb(1'b1, REG_CMD, {8'hA5, 3'h0, rmw, bin, pg, op});
    do @(negedge core_clk); while (op_start !== 1'b1);
    `CHK(op_code, op)
    `CHK(op_page, pg)
    `CHK(op_buf2, (op == OP_XFR_B2) || (op == OP_CMP_B2) || (op == OP_RW_B2))
    `CHK(op_rmw, rmw)
    @(negedge core_clk);
    `CHK(busy, 1'b1)
    // A status read must be served while the long rewrite is running
    if (rw) begin
      idle();
      status();
      `CHK(st, exp_st(1'b1))
    end
    while (busy !== 1'b0) @(negedge core_clk);
    `CHK(bcnt >= (rw ? RW_T : 20) && bcnt <= (rw ? RW_T : 20) + 1, 1'b1)
    if (op == OP_CMP_B1 || op == OP_CMP_B2) begin
      cmp_exp = mism;
      `CHK(cmp_flag, mism)
    end
    idle();
    status();
    `CHK(st, exp_st(1'b0))
  endtask

  initial begin
    void'($urandom(59));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    // Unmapped address answers with an error and reads zero
    apb(1'b0, 8'h08, 32'h0);
    `CHK({last_err, rd}, 33'h1_0000_0000)
    // An unknown opcode must not start any operation
    apb(1'b1, REG_CMD, 32'h0000_0000);
    bad = 1'b0;
    repeat (400) @(negedge core_clk) if (op_start === 1'b1) bad = 1'b1;
    `CHK(bad, 1'b0)
    idle();
    for (int i = 0; i < 2; i++) begin
      // The plain rewrites stand for the host's periodic page refresh
      foreach (ops[k]) page_op(ops[k], 1'b0);
    end
    page_op(OP_RW_B1, 1'b1);
    page_op(OP_RW_B2, 1'b1);
    summarize();
  end
endmodule
